// *** rtl/cps_pkg.sv ***
package cps_pkg;
  localparam int NCORE = 4;
  localparam int CIDW = 3;
  localparam int VECW = 32;
  // Register map, byte addresses of 32-bit words
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_PWR = 8'h08;
  localparam logic [7:0] OFS_VEC0 = 8'h10;
  // Control fields
  localparam int CTRL_CORE_ON = 0;
  localparam int CTRL_CM_POLICY = 8;
  localparam logic [31:0] VEC_RESET = 32'hbfc00000;
  // Timing
  localparam int CLK_NS = 5;
  localparam int RST_HOLD_NS = 40;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRST_HOLD_NS = 20;
  localparam int TRST_HOLD_CYC = (TRST_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNTW = 4;
  // Strap codes per core
  localparam logic [1:0] STRAP_OFF = 2'h0;
  localparam logic [1:0] STRAP_CLKOFF = 2'h1;
  localparam logic [1:0] STRAP_RUN = 2'h2;
  typedef enum logic [2:0] {DS_OFF, DS_ISO, DS_PWRUP, DS_CLK, DS_RST, DS_RUN, DS_CLKOFF} cps_dstate_t;
  typedef struct packed {
    logic pwr_en;
    logic clk_en;
    logic rst;
    logic iso;
    logic trst;
  } cps_dom_t;
  typedef struct packed {
    logic cold;
    logic warm;
    logic keep_cm_stat;
    logic keep_wdt;
  } cps_side_t;
endpackage

// *** rtl/cps_seq.sv ***
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Function
// - System reset puts sequencer in reset
// - Sideband marks start as cold or warm
// - Straps pick off, clock-off or run
// - Cold start powers selected cores
// - Coherence manager on if any core, unless policy is set and every live core sleeps
// - Clock then reset after supply good
// - Warm start returns to cold configuration
// - Isolation raised before power removed
// - Powered configured domains only reset
// - Sideband keeps or resets status, watchdogs
// - Test-logic reset after core power-up
// - Registers drive per-core boot vectors
// - Each core gets a unique number
// - Gate clock or power per core
// - Manager power follows cores and policy
// - Reset and clock gating share sequence
module cps_seq (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Start qualification and straps
  input wire cps_pkg::cps_side_t side_i,
  input wire logic [2*cps_pkg::NCORE-1:0] strap_i,
  input wire logic [cps_pkg::NCORE-1:0] cold_sel_i,
  // Domain feedback, index NCORE is the coherence manager
  input wire logic [cps_pkg::NCORE:0] supply_ok_i,
  input wire logic [cps_pkg::NCORE-1:0] sleep_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Domain controls
  output cps_pkg::cps_dom_t [cps_pkg::NCORE:0] dom_o,
  output logic [cps_pkg::NCORE*cps_pkg::VECW-1:0] boot_vector_base_in_o,
  output logic [cps_pkg::NCORE*cps_pkg::CIDW-1:0] core_num_o,
  output logic cm_stat_rst_o,
  output logic wdt_rst_o
);
  import cps_pkg::*;
  localparam int ND = NCORE + 1;

  cps_dstate_t st [ND];
  logic [CNTW-1:0] cnt [ND];
  logic [ND-1:0] want;
  logic [ND-1:0] clk_only;
  logic [ND-1:0] restart;
  logic [NCORE-1:0] sw_on;
  logic cm_policy;
  logic [VECW-1:0] vec [NCORE];
  logic [ND-1:0] running;
  logic [ND-1:0] powered;

  // Per-core targets: straps select, cold-start pins power up, software may override later
  logic [NCORE-1:0] core_want;
  logic [NCORE-1:0] core_clkoff;
  logic any_core;
  logic all_sleep;
  always_comb begin
    for (int i = 0; i < NCORE; i++) begin
      core_want[i] = sw_on[i] & (strap_i[2*i +: 2] == STRAP_RUN);
      core_clkoff[i] = sw_on[i] & (strap_i[2*i +: 2] == STRAP_CLKOFF);
    end
  end
  assign any_core = |(core_want | core_clkoff);
  // Manager may be dropped only when every live core sleeps, if policy allows
  assign all_sleep = &(sleep_i | ~(core_want | core_clkoff));
  assign want = {any_core & ~(cm_policy & all_sleep), core_want};
  assign clk_only = {1'b0, core_clkoff};
  assign restart = {ND{side_i.cold | side_i.warm}};

  // Registers
  wire wr_ctrl = wr_i & (addr_i == OFS_CTRL);
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sw_on <= '0;
      cm_policy <= 1'b0;
    end else if (ce_i) begin
      if (side_i.cold | side_i.warm) begin
        sw_on <= cold_sel_i;
      end else if (wr_ctrl) begin
        sw_on <= wdata_i[CTRL_CORE_ON +: NCORE];
        cm_policy <= wdata_i[CTRL_CM_POLICY];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCORE; g++) begin : g_vec
      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          vec[g] <= VEC_RESET;
        end else if (ce_i && wr_i && addr_i == OFS_VEC0 + 8'(4 * g)) begin
          vec[g] <= wdata_i;
        end
      end
      assign boot_vector_base_in_o[g*VECW +: VECW] = vec[g];
      assign core_num_o[g*CIDW +: CIDW] = CIDW'(g);
    end
  endgenerate

  // Read data, one cycle later
  wire [31:0] stat_word = {{(32-2*ND){1'b0}}, powered, running};
  wire [31:0] ctrl_word = {23'h0, cm_policy, {(8-NCORE){1'b0}}, sw_on};
  logic [31:0] rsel;
  always_comb begin
    rsel = 32'h0;
    if (addr_i == OFS_CTRL) rsel = ctrl_word;
    if (addr_i == OFS_STAT) rsel = stat_word;
    if (addr_i == OFS_PWR) rsel = {{(32-ND){1'b0}}, supply_ok_i};
    for (int i = 0; i < NCORE; i++) begin
      if (addr_i == OFS_VEC0 + 8'(4 * i)) rsel = vec[i];
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) rdata_o <= 32'h0;
    else if (ce_i && rd_i) rdata_o <= rsel;
  end

  // Warm-start sideband: reset status and watchdogs unless asked to keep them
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cm_stat_rst_o <= 1'b1;
      wdt_rst_o <= 1'b1;
    end else if (ce_i) begin
      cm_stat_rst_o <= side_i.cold | (side_i.warm & ~side_i.keep_cm_stat);
      wdt_rst_o <= side_i.cold | (side_i.warm & ~side_i.keep_wdt);
    end
  end

  // One sequencer per domain
  generate
    for (g = 0; g < ND; g++) begin : g_dom
      cps_dstate_t next_st;
      logic [CNTW-1:0] next_cnt;
      wire on_req = want[g] | clk_only[g];
      always_comb begin
        next_st = st[g];
        next_cnt = cnt[g];
        case (st[g])
          DS_OFF: if (on_req) next_st = DS_PWRUP;
          DS_PWRUP: if (supply_ok_i[g]) next_st = DS_CLK;
          DS_CLK: begin
            next_st = DS_RST;
            next_cnt = CNTW'(RST_HOLD_CYC);
          end
          DS_RST: begin
            if (cnt[g] != '0) next_cnt = cnt[g] - 1'b1;
            else next_st = clk_only[g] ? DS_CLKOFF : DS_RUN;
          end
          DS_RUN, DS_CLKOFF: begin
            if (!on_req) next_st = DS_ISO;
            else if (restart[g]) begin
              next_st = DS_RST;
              next_cnt = CNTW'(RST_HOLD_CYC);
            end else if (clk_only[g] != (st[g] == DS_CLKOFF)) next_st = clk_only[g] ? DS_CLKOFF : DS_RUN;
          end
          DS_ISO: next_st = DS_OFF;
          default: next_st = DS_OFF;
        endcase
      end
      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          st[g] <= DS_OFF;
          cnt[g] <= '0;
        end else if (ce_i) begin
          st[g] <= next_st;
          cnt[g] <= next_cnt;
        end
      end
      // Test reset holds until the reset window is half spent, so the TAP is quiet when the core starts
      wire [CNTW-1:0] trst_cut = CNTW'(RST_HOLD_CYC - TRST_HOLD_CYC);
      wire trst_next = (next_st == DS_OFF) | (next_st == DS_ISO) | (next_st == DS_PWRUP) | (next_st == DS_CLK) |
        ((next_st == DS_RST) & (next_cnt > trst_cut));
      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          dom_o[g] <= '{pwr_en: 1'b0, clk_en: 1'b0, rst: 1'b1, iso: 1'b1, trst: 1'b1};
        end else if (ce_i) begin
          dom_o[g].pwr_en <= (next_st != DS_OFF);
          dom_o[g].clk_en <= (next_st == DS_CLK) | (next_st == DS_RST) | (next_st == DS_RUN);
          dom_o[g].rst <= (next_st != DS_RUN) & (next_st != DS_CLKOFF);
          dom_o[g].iso <= (next_st != DS_RUN) & (next_st != DS_CLKOFF);
          dom_o[g].trst <= trst_next;
        end
      end
      assign running[g] = (st[g] == DS_RUN);
      assign powered[g] = (st[g] != DS_OFF);
    end
  endgenerate
endmodule // cps_seq

// *** verification/cps_seq_assertions.sv ***
`timescale 1ns/1ps
module cps_seq_assertions (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Watched ports
  input wire cps_pkg::cps_side_t side_i,
  input wire logic [cps_pkg::NCORE:0] supply_ok_i,
  input wire cps_pkg::cps_dom_t [cps_pkg::NCORE:0] dom_o,
  input wire logic [cps_pkg::NCORE*cps_pkg::CIDW-1:0] core_num_o,
  input wire logic cm_stat_rst_o,
  input wire logic wdt_rst_o
);
  import cps_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_iso_first; $fell(dom_o[0].pwr_en) |-> $past(dom_o[0].iso); endproperty
  a_iso_first: assert property (p_iso_first) else $error("power cut without isolation");
  property p_clk_ok; $rose(dom_o[0].clk_en) |-> $past(supply_ok_i[0]); endproperty
  a_clk_ok: assert property (p_clk_ok) else $error("clock on before supply good");
  property p_rst_hold; $rose(dom_o[0].clk_en) |-> dom_o[0].rst [*8]; endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset too short");
  property p_clk_first; !dom_o[0].rst |-> dom_o[0].clk_en && dom_o[0].pwr_en; endproperty
  a_clk_first: assert property (p_clk_first) else $error("reset released without clock");
  property p_iso_rel; $fell(dom_o[0].iso) |-> $fell(dom_o[0].rst); endproperty
  a_iso_rel: assert property (p_iso_rel) else $error("isolation released apart from reset");
  property p_trst; $fell(dom_o[0].trst) |-> dom_o[0].rst; endproperty
  a_trst: assert property (p_trst) else $error("test reset outside reset");
  property p_num; core_num_o == 12'h688; endproperty
  a_num: assert property (p_num) else $error("core numbers wrong");
  property p_cold; side_i.cold |=> cm_stat_rst_o && wdt_rst_o; endproperty
  a_cold: assert property (p_cold) else $error("cold start resets missing");
  property p_keep; side_i.warm && side_i.keep_wdt && !side_i.cold |=> !wdt_rst_o; endproperty
  a_keep: assert property (p_keep) else $error("watchdog reset not kept");
  property p_cm; $rose(dom_o[0].pwr_en) |-> ##[0:4] dom_o[4].pwr_en; endproperty
  a_cm: assert property (p_cm) else $error("manager not powered");
  c_run: cover property ($fell(dom_o[0].rst));
  c_cm_off: cover property ($fell(dom_o[4].pwr_en));
  c_warm: cover property (side_i.warm ##1 dom_o[0].rst);
endmodule // cps_seq_assertions
bind cps_seq cps_seq_assertions chk_u (.mclk_i(mclk_i), .rst_i(rst_i), .side_i(side_i), .supply_ok_i(supply_ok_i),
  .dom_o(dom_o), .core_num_o(core_num_o), .cm_stat_rst_o(cm_stat_rst_o), .wdt_rst_o(wdt_rst_o));

// *** verification/cps_dom_model.sv ***
`timescale 1ns/1ps
module cps_dom_model (
  // Clock and domain controls
  input wire logic mclk_i,
  input wire cps_pkg::cps_dom_t [4:0] dom_i,
  // Ramp length shared by all domains, wait instruction per core
  input wire logic [3:0] dly_i,
  input wire logic [3:0] wait_i,
  // Feedback
  output logic [4:0] supply_ok_o,
  output logic [3:0] sleep_o
);
  import cps_pkg::*;
  logic [4:0][3:0] ramp;
  // Rail collapses at once but climbs slowly, so a hasty sequencer is caught
  always_ff @(posedge mclk_i) begin
    for (int d = 0; d < 5; d++) ramp[d] <= !dom_i[d].pwr_en ? 4'h0 : (ramp[d] < dly_i) ? ramp[d] + 4'h1 : ramp[d];
    for (int c = 0; c < 4; c++) sleep_o[c] <= wait_i[c] && dom_i[c].clk_en && !dom_i[c].rst;
  end
  always_comb begin
    for (int d = 0; d < 5; d++) supply_ok_o[d] = dom_i[d].pwr_en && ramp[d] >= dly_i;
  end
endmodule // cps_dom_model

// *** verification/cps_seq_tb.sv ***
`timescale 1ns/1ps
module cps_seq_tb;
  import cps_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  cps_side_t side_i = '0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [3:0] wait_c = 4'h0;
  logic [3:0] dly = 4'h2;
  logic [4:0] supply_ok;
  logic [3:0] sleep;
  logic [31:0] rdata_o;
  cps_dom_t [4:0] dom_o;
  logic [127:0] vec;
  logic [11:0] core_num;
  int error_cnt = 0;
  int checks = 0;
  always #2.5 mclk_i = ~mclk_i;
  cps_dom_model model_u (.mclk_i(mclk_i), .dom_i(dom_o), .dly_i(dly), .wait_i(wait_c), .supply_ok_o(supply_ok),
    .sleep_o(sleep));
  // Straps: core3 run, core2 off, core1 clock-off, core0 run
  cps_seq dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1), .side_i(side_i), .strap_i(8'h86), .cold_sel_i(4'h9),
    .supply_ok_i(supply_ok), .sleep_i(sleep), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .dom_o(dom_o), .boot_vector_base_in_o(vec), .core_num_o(core_num), .cm_stat_rst_o(),
    .wdt_rst_o());
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk("rdata", rdata_o, e);
  endtask
  task automatic sd(input cps_side_t v);
    @(posedge mclk_i);
    side_i <= v;
    @(posedge mclk_i);
    side_i <= '0;
    @(posedge mclk_i);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    chk("dom0", dom_o[0], 32'h07);
    rst_i <= 1'b0;
    rd(OFS_VEC0, VEC_RESET);
    rd(8'hfc, 32'h0);
    sd(4'h8);
    wait (dom_o[0].rst === 1'b0 && dom_o[3].rst === 1'b0);
    #1 chk("core0", dom_o[0], 32'h18);
    chk("core2", dom_o[2].pwr_en, 1'b0);
    chk("cm", dom_o[4].pwr_en, 1'b1);
    chk("num", core_num, 32'h688);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_VEC0 + 8'(4 * i), 32'h80000000 | (32'(i) << 12));
      rd(OFS_VEC0 + 8'(4 * i), 32'h80000000 | (32'(i) << 12));
      chk("vec", vec[i*32 +: 32], 32'h80000000 | (32'(i) << 12));
    end
    $display("cold start and vectors done");
    wr(OFS_CTRL, 32'h8);
    wait (dom_o[0].pwr_en === 1'b0);
    #1 chk("off0", dom_o[0], 32'h07);
    dly <= 4'h9;
    wr(OFS_CTRL, 32'h9);
    wait (dom_o[0].rst === 1'b0);
    #1 chk("on0", dom_o[0], 32'h18);
    $display("gating done");
    wr(OFS_CTRL, 32'h1);
    wait (dom_o[3].pwr_en === 1'b0);
    sd(4'h7);
    #1 chk("warm0", {dom_o[0].pwr_en, dom_o[0].rst}, 32'h3);
    wait (dom_o[3].rst === 1'b0);
    #1 chk("warm3", dom_o[3], 32'h18);
    $display("warm start done");
    wr(OFS_CTRL, 32'h109);
    wait_c <= 4'hf;
    wait (dom_o[4].pwr_en === 1'b0);
    #1 chk("cm off", dom_o[4].iso, 1'b1);
    $display("policy done");
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    error_cnt++;
    give_verdict();
  end
endmodule // cps_seq_tb
